// ### inc/sogc_pkg.sv
// package: register map, field layout and datapath constants for system offset/gain correction
`default_nettype none
package sogc_pkg;
  localparam int DATA_W = 24; // sample and calibration word width
  localparam int ADDR_W = 8; // register address width
  localparam int NUM_DEST = 8; // destination data registers
  localparam int SEL_W = 2; // set selector width per destination
  localparam int DEST_W = 3; // destination index width
  localparam int GAIN_FRAC = 23; // gain LSB weight is 2^-23
  // register offsets
  localparam logic [ADDR_W-1:0] OFFS_OFFSET_SET_A = 8'h13;
  localparam logic [ADDR_W-1:0] OFFS_OFFSET_SET_B = 8'h14;
  localparam logic [ADDR_W-1:0] OFFS_GAIN_SET_A = 8'h15;
  localparam logic [ADDR_W-1:0] OFFS_GAIN_SET_B = 8'h16;
  localparam logic [ADDR_W-1:0] OFFS_SET_CHOICE = 8'h12;
  // reset values
  localparam logic [DATA_W-1:0] RST_OFFSET = 24'h000000;
  localparam logic [DATA_W-1:0] RST_GAIN = 24'h800000; // unity gain
  localparam logic [15:0] RST_CHOICE = 16'h0000; // every destination uses set A
  // selector codes
  localparam logic [SEL_W-1:0] SEL_SET_A = 2'h0;
  localparam logic [SEL_W-1:0] SEL_SET_B = 2'h1;
  // full-scale limits of the signed result
  localparam logic signed [DATA_W-1:0] FS_MAX = 24'sh7FFFFF;
  localparam logic signed [DATA_W-1:0] FS_MIN = -24'sh800000;
  // one calibration set
  typedef struct packed {
    logic [DATA_W-1:0] offset;
    logic [DATA_W-1:0] gain;
  } sogc_cal_set_t;
  // one sample on its way to a destination
  typedef struct packed {
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] value;
  } sogc_sample_t;
endpackage
`default_nettype wire

// ### rtl/sogc_cal_reg.sv
// one 24-bit calibration register with software write and calibration overwrite
`default_nettype none
module sogc_cal_reg
  import sogc_pkg::*;
#(
  parameter logic [DATA_W-1:0] RESET_VAL = 24'h000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sw_we, // software write strobe
  input wire logic [DATA_W-1:0] sw_data,
  input wire logic cal_we, // calibration result strobe
  input wire logic [DATA_W-1:0] cal_data,
  output logic [DATA_W-1:0] value
);
  logic [DATA_W-1:0] val_q;
  logic [DATA_W-1:0] val_d;
  // software write takes precedence over a calibration result in the same cycle
  assign val_d = sw_we ? sw_data : (cal_we ? cal_data : val_q);
  // value persists until either writer replaces it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      val_q <= RESET_VAL;
    end else begin
      val_q <= val_d;
    end
  end
  assign value = val_q;
endmodule
`default_nettype wire

// ### rtl/sogc_gain_mul.sv
// gain multiply with truncation and saturation to 24 bits
`default_nettype none
module sogc_gain_mul
  import sogc_pkg::*;
(
  input wire logic signed [DATA_W:0] din, // offset-corrected, one guard bit
  input wire logic [DATA_W-1:0] gain, // unsigned 1.23 fixed point
  output logic signed [DATA_W-1:0] dout
);
  logic signed [2*DATA_W+1:0] prod;
  logic signed [2*DATA_W+1:0] shifted;
  logic over_hi;
  logic over_lo;
  // gain kept unsigned by a zero sign bit, so factors span 0 to just under 2
  assign prod = din * $signed({1'b0, gain});
  // drop the 23 fraction bits: truncation toward minus infinity
  assign shifted = prod >>> GAIN_FRAC;
  assign over_hi = shifted > $signed({{(DATA_W+2){1'b0}}, FS_MAX});
  assign over_lo = shifted < $signed({{(DATA_W+2){1'b1}}, FS_MIN});
  // clip instead of wrapping at full scale
  assign dout = over_hi ? FS_MAX : (over_lo ? FS_MIN : shifted[DATA_W-1:0]);
endmodule
`default_nettype wire

// ### rtl/sogc_top.sv
// system offset and gain correction stage with its calibration registers
// Summary of operation
// - subtract chosen set offset per destination selector
// - offsets are always two's complement
// - registers read back; persist until rewrite/calibration
// - offset after self-cal, before gain multiply
// - correction precedes unipolar 2x/bipolar 1x scaling
// - multiply by chosen set's gain
// - gain is unsigned 1.23 fixed point
// - gain spans zero to 1.999999881
// - code 00 set A, 01 B, else none
`default_nettype none
module sogc_top
  import sogc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic SAMPLE_VALID, // self-calibrated sample strobe
  input wire sogc_sample_t SAMPLE_IN,
  input wire logic UNIPOLAR_BIPOLAR_CHOICE, // 1 = unipolar (2x scale)
  input wire logic CAL_WE_OFF_A, // on-demand system calibration results
  input wire logic CAL_WE_OFF_B,
  input wire logic CAL_WE_GAIN_A,
  input wire logic CAL_WE_GAIN_B,
  input wire logic [DATA_W-1:0] CAL_DATA,
  output logic RESULT_VALID,
  output sogc_sample_t RESULT_OUT
);
  // register decode
  logic wr_off_a;
  logic wr_off_b;
  logic wr_gain_a;
  logic wr_gain_b;
  logic wr_choice;
  logic [DATA_W-1:0] off_a;
  logic [DATA_W-1:0] off_b;
  logic [DATA_W-1:0] gain_a;
  logic [DATA_W-1:0] gain_b;
  logic [15:0] choice_q; // per_destination_set_choice, two bits per destination
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  assign wr_off_a = REG_WR && (REG_ADDR == OFFS_OFFSET_SET_A);
  assign wr_off_b = REG_WR && (REG_ADDR == OFFS_OFFSET_SET_B);
  assign wr_gain_a = REG_WR && (REG_ADDR == OFFS_GAIN_SET_A);
  assign wr_gain_b = REG_WR && (REG_ADDR == OFFS_GAIN_SET_B);
  assign wr_choice = REG_WR && (REG_ADDR == OFFS_SET_CHOICE);

  // four calibration registers
  sogc_cal_reg #(.RESET_VAL(RST_OFFSET)) u_off_a (
    .clk(CORE_CLK), .rst_n(RST_N), .sw_we(wr_off_a), .sw_data(REG_WDATA[DATA_W-1:0]),
    .cal_we(CAL_WE_OFF_A), .cal_data(CAL_DATA), .value(off_a)
  );
  sogc_cal_reg #(.RESET_VAL(RST_OFFSET)) u_off_b (
    .clk(CORE_CLK), .rst_n(RST_N), .sw_we(wr_off_b), .sw_data(REG_WDATA[DATA_W-1:0]),
    .cal_we(CAL_WE_OFF_B), .cal_data(CAL_DATA), .value(off_b)
  );
  sogc_cal_reg #(.RESET_VAL(RST_GAIN)) u_gain_a (
    .clk(CORE_CLK), .rst_n(RST_N), .sw_we(wr_gain_a), .sw_data(REG_WDATA[DATA_W-1:0]),
    .cal_we(CAL_WE_GAIN_A), .cal_data(CAL_DATA), .value(gain_a)
  );
  sogc_cal_reg #(.RESET_VAL(RST_GAIN)) u_gain_b (
    .clk(CORE_CLK), .rst_n(RST_N), .sw_we(wr_gain_b), .sw_data(REG_WDATA[DATA_W-1:0]),
    .cal_we(CAL_WE_GAIN_B), .cal_data(CAL_DATA), .value(gain_b)
  );

  // selector register, only software writes it
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      choice_q <= RST_CHOICE;
    end else if (wr_choice) begin
      choice_q <= REG_WDATA[15:0];
    end
  end

  // read mux: unmapped addresses read zero, upper bits zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        OFFS_OFFSET_SET_A: rdata_d = {8'h00, off_a};
        OFFS_OFFSET_SET_B: rdata_d = {8'h00, off_b};
        OFFS_GAIN_SET_A: rdata_d = {8'h00, gain_a};
        OFFS_GAIN_SET_B: rdata_d = {8'h00, gain_b};
        OFFS_SET_CHOICE: rdata_d = {16'h0000, choice_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign REG_RDATA = rdata_q;

  // datapath: select set for this sample's destination
  logic [SEL_W-1:0] dest_sel;
  logic use_a;
  logic use_b;
  logic apply_cal;
  logic [DATA_W-1:0] sel_off;
  logic [DATA_W-1:0] sel_gain;
  logic signed [DATA_W:0] diff;
  logic signed [DATA_W-1:0] scaled;
  logic signed [DATA_W-1:0] corrected;
  logic signed [DATA_W:0] final_wide;
  logic signed [DATA_W-1:0] final_val;

  assign dest_sel = choice_q[SAMPLE_IN.dest*SEL_W +: SEL_W];
  assign use_a = (dest_sel == SEL_SET_A);
  assign use_b = (dest_sel == SEL_SET_B);
  assign apply_cal = use_a || use_b; // codes 10 and 11 bypass
  assign sel_off = use_b ? off_b : off_a;
  assign sel_gain = use_b ? gain_b : gain_a;

  // offset subtract on the self-calibrated input, guard bit avoids wrap
  assign diff = $signed({SAMPLE_IN.value[DATA_W-1], SAMPLE_IN.value})
              - $signed({sel_off[DATA_W-1], sel_off});

  sogc_gain_mul u_mul (
    .din(diff),
    .gain(sel_gain),
    .dout(scaled)
  );

  // bypass leaves the sample as self-calibration produced it
  assign corrected = apply_cal ? scaled : $signed(SAMPLE_IN.value);

  // mode scaling last: 2x unipolar, 1x bipolar, clipped at full scale
  assign final_wide = UNIPOLAR_BIPOLAR_CHOICE ? ($signed({corrected, 1'b0}))
                    : $signed({corrected[DATA_W-1], corrected});
  assign final_val = (final_wide > $signed({1'b0, FS_MAX})) ? FS_MAX
                   : (final_wide < $signed({1'b1, FS_MIN})) ? FS_MIN
                   : final_wide[DATA_W-1:0];

  // result register, one cycle after the sample
  logic valid_q;
  sogc_sample_t result_q;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      valid_q <= 1'b0;
      result_q <= '0;
    end else begin
      valid_q <= SAMPLE_VALID;
      if (SAMPLE_VALID) begin
        result_q <= '{dest: SAMPLE_IN.dest, value: final_val};
      end
    end
  end
  assign RESULT_VALID = valid_q;
  assign RESULT_OUT = result_q;

  // checks
  a_bypass_passes: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && !apply_cal && !UNIPOLAR_BIPOLAR_CHOICE |=> RESULT_OUT.value == $past(SAMPLE_IN.value))
    else $error("bypass destination altered the sample");
  a_unity_offset_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && use_a && gain_a == RST_GAIN && !UNIPOLAR_BIPOLAR_CHOICE
    && $signed(diff) <= $signed({1'b0, FS_MAX}) && $signed(diff) >= $signed({1'b1, FS_MIN})
    |=> RESULT_OUT.value == $past(diff[DATA_W-1:0]))
    else $error("set A offset not subtracted");
  a_write_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_off_a ##1 REG_RD && REG_ADDR == OFFS_OFFSET_SET_A && !CAL_WE_OFF_A
    |=> REG_RDATA == {8'h00, $past(REG_WDATA[DATA_W-1:0], 2)})
    else $error("offset A did not read back");
  a_gain_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !wr_gain_b && !CAL_WE_GAIN_B |=> gain_b == $past(gain_b))
    else $error("gain B changed without a writer");
  a_zero_gain: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && apply_cal && sel_gain == 24'h000000 |=> RESULT_OUT.value == 24'h000000)
    else $error("zero gain gave nonzero result");
  a_unipolar_double: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && !apply_cal && UNIPOLAR_BIPOLAR_CHOICE && SAMPLE_IN.value == 24'h000001
    |=> RESULT_OUT.value == 24'h000002)
    else $error("unipolar scale not 2x");
  a_sat_high: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && apply_cal && !UNIPOLAR_BIPOLAR_CHOICE && diff == 25'sh07FFFFF && sel_gain == 24'hFFFFFF
    |=> RESULT_OUT.value == FS_MAX)
    else $error("overflow wrapped instead of clipping");
  a_valid_follows: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID |=> RESULT_VALID ##1 (RESULT_VALID == $past(SAMPLE_VALID)))
    else $error("result strobe misaligned");
  a_neg_offset: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && use_b && gain_b == RST_GAIN && off_b == 24'hFFFFFF && !UNIPOLAR_BIPOLAR_CHOICE
    && SAMPLE_IN.value == 24'h000000 |=> RESULT_OUT.value == 24'h000001)
    else $error("offset not treated as signed");

  // register bus checks: read data stands one cycle, zero otherwise
  // read port
  a_rdata_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !REG_RD |=> REG_RDATA == 32'h00000000)
    else $error("read data not zero outside a read");

  // offset A read returns the stored value
  a_offa_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    REG_RD && REG_ADDR == OFFS_OFFSET_SET_A |=> REG_RDATA == {8'h00, $past(off_a)})
    else $error("offset A read mismatch");

  // offset B read returns the stored value
  a_offb_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    REG_RD && REG_ADDR == OFFS_OFFSET_SET_B |=> REG_RDATA == {8'h00, $past(off_b)})
    else $error("offset B read mismatch");

  // gain A read returns the stored value
  a_gaina_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    REG_RD && REG_ADDR == OFFS_GAIN_SET_A |=> REG_RDATA == {8'h00, $past(gain_a)})
    else $error("gain A read mismatch");

  // gain B read returns the stored value
  a_gainb_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    REG_RD && REG_ADDR == OFFS_GAIN_SET_B |=> REG_RDATA == {8'h00, $past(gain_b)})
    else $error("gain B read mismatch");

  // selector read returns the stored choices
  a_choice_readback: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    REG_RD && REG_ADDR == OFFS_SET_CHOICE |=> REG_RDATA == {16'h0000, $past(choice_q)})
    else $error("selector read mismatch");

  // top byte of every read is zero, no register is wider than 24 bits
  a_upper_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    REG_RD |=> REG_RDATA[31:24] == 8'h00)
    else $error("read data top byte not zero");

  // reset clears the outputs at the next edge
  a_reset_clear: assert property (@(posedge CORE_CLK)
    !RST_N |=> !RESULT_VALID && REG_RDATA == 32'h00000000)
    else $error("outputs not cleared by reset");

  // registers persist while no writer is active
  a_offa_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !wr_off_a && !CAL_WE_OFF_A |=> off_a == $past(off_a))
    else $error("offset A changed without a writer");

  // offset B keeps its value between writes
  a_offb_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !wr_off_b && !CAL_WE_OFF_B |=> off_b == $past(off_b))
    else $error("offset B changed without a writer");

  // gain A keeps its value between writes
  a_gaina_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !wr_gain_a && !CAL_WE_GAIN_A |=> gain_a == $past(gain_a))
    else $error("gain A changed without a writer");

  // a software write lands in the next cycle
  a_gaina_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_gain_a |=> gain_a == $past(REG_WDATA[DATA_W-1:0]))
    else $error("gain A write lost");

  // offset B software write lands
  a_offb_write: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_off_b |=> off_b == $past(REG_WDATA[DATA_W-1:0]))
    else $error("offset B write lost");

  // calibration result overwrites offset A
  a_cal_offa: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CAL_WE_OFF_A && !wr_off_a |=> off_a == $past(CAL_DATA))
    else $error("calibration did not replace offset A");

  // calibration result overwrites offset B
  a_cal_offb: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CAL_WE_OFF_B && !wr_off_b |=> off_b == $past(CAL_DATA))
    else $error("calibration did not replace offset B");

  // calibration result overwrites gain A
  a_cal_gaina: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CAL_WE_GAIN_A && !wr_gain_a |=> gain_a == $past(CAL_DATA))
    else $error("calibration did not replace gain A");

  // calibration result overwrites gain B
  a_cal_gainb: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CAL_WE_GAIN_B && !wr_gain_b |=> gain_b == $past(CAL_DATA))
    else $error("calibration did not replace gain B");

  // software wins when both writers strike in one cycle
  a_sw_beats_cal: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    wr_off_a && CAL_WE_OFF_A |=> off_a == $past(REG_WDATA[DATA_W-1:0]))
    else $error("calibration beat a software write");

  // datapath checks: selection, order of steps, clipping
  // codes 10 and 11 leave a bipolar sample untouched
  a_bypass_codes: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && choice_q[SAMPLE_IN.dest*SEL_W+1] && !UNIPOLAR_BIPOLAR_CHOICE
    |=> RESULT_OUT.value == $past(SAMPLE_IN.value))
    else $error("disabled code still corrected");

  // set B with unity gain subtracts only its offset
  a_unity_offset_b: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && use_b && gain_b == RST_GAIN && !UNIPOLAR_BIPOLAR_CHOICE
    && $signed(diff) <= $signed({1'b0, FS_MAX}) && $signed(diff) >= $signed({1'b1, FS_MIN})
    |=> RESULT_OUT.value == $past(diff[DATA_W-1:0]))
    else $error("set B offset not subtracted");

  // destination travels with its sample
  a_dest_carried: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID |=> RESULT_OUT.dest == $past(SAMPLE_IN.dest))
    else $error("destination lost");

  // result holds until the next sample
  a_result_holds: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !SAMPLE_VALID |=> RESULT_OUT == $past(RESULT_OUT))
    else $error("result changed without a sample");

  // no sample, no result strobe
  a_valid_idle: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !SAMPLE_VALID |=> !RESULT_VALID)
    else $error("result strobe without a sample");

  // gain of one or more never shrinks a positive difference up to full scale
  a_gain_grows: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && apply_cal && !UNIPOLAR_BIPOLAR_CHOICE && sel_gain[DATA_W-1]
    && $signed(diff) > 0 && $signed(diff) <= $signed({1'b0, FS_MAX})
    |=> $signed(RESULT_OUT.value) >= $signed($past(diff)))
    else $error("gain above one shrank the result");

  // gain below one always shrinks a positive difference
  a_gain_shrinks: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && apply_cal && !UNIPOLAR_BIPOLAR_CHOICE && !sel_gain[DATA_W-1] && $signed(diff) > 0
    |=> $signed(RESULT_OUT.value) < $signed($past(diff)))
    else $error("gain below one did not shrink the result");

  // large positive difference with gain of one or more clips high
  a_clip_high: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && apply_cal && !UNIPOLAR_BIPOLAR_CHOICE && sel_gain >= RST_GAIN
    && $signed(diff) > $signed({1'b0, FS_MAX})
    |=> RESULT_OUT.value == FS_MAX)
    else $error("positive overflow not clipped");

  // large negative difference with gain of one or more clips low
  a_clip_low: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && apply_cal && !UNIPOLAR_BIPOLAR_CHOICE && sel_gain >= RST_GAIN
    && $signed(diff) < $signed({1'b1, FS_MIN})
    |=> RESULT_OUT.value == FS_MIN)
    else $error("negative overflow not clipped");

  // unipolar doubling leaves an even result unless clipped high
  a_unipolar_even: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    SAMPLE_VALID && UNIPOLAR_BIPOLAR_CHOICE
    |=> RESULT_OUT.value[0] == 1'b0 || RESULT_OUT.value == FS_MAX)
    else $error("unipolar result not doubled");
endmodule
`default_nettype wire

// ### testbench/sogc_top_tb.sv
// self-checking bench for the system offset and gain correction stage
`default_nettype none
module sogc_top_tb
  import sogc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, reg_wr, reg_rd, sample_valid, ubc;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] cal_we; // off a, off b, gain a, gain b
  logic [DATA_W-1:0] cal_data;
  logic result_valid;
  sogc_sample_t sample_in, result_out;
  logic [DATA_W-1:0] m_reg [4]; // bench copy of offsets and gains
  logic [15:0] m_choice; // bench copy of set choices
  int n_fail, comparisons, cycles;
  sogc_top sogc_top_i (.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SAMPLE_VALID(sample_valid),
    .SAMPLE_IN(sample_in), .UNIPOLAR_BIPOLAR_CHOICE(ubc), .CAL_WE_OFF_A(cal_we[0]),
    .CAL_WE_OFF_B(cal_we[1]), .CAL_WE_GAIN_A(cal_we[2]), .CAL_WE_GAIN_B(cal_we[3]),
    .CAL_DATA(cal_data), .RESULT_VALID(result_valid), .RESULT_OUT(result_out));
  // 25 ns clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, far above the fewer than a thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  // saturate to the signed 24-bit full scale
  function automatic logic signed [63:0] clip(input logic signed [63:0] x);
    if (x > 64'sh7FFFFF) return 64'sh7FFFFF;
    if (x < -64'sh800000) return -64'sh800000;
    return x;
  endfunction
  // expected corrected value: offset, gain, truncate, clip, then scale
  function automatic logic [23:0] model(input logic [23:0] v, input logic [2:0] d, input logic u);
    logic [1:0] s;
    logic signed [63:0] x, o, g;
    s = m_choice[2*d+:2];
    x = {{40{v[23]}}, v};
    if (s < 2'h2) begin
      o = {{40{m_reg[s][23]}}, m_reg[s]};
      g = {40'h0, m_reg[2+s]};
      x = clip(((x - o) * g) >>> GAIN_FRAC);
    end
    if (u) x = clip(x * 2);
    return x[23:0];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a >= 8'h13 && a <= 8'h16) m_reg[a-8'h13] = d[23:0];
    if (a == 8'h12) m_choice = d[15:0];
  endtask
  // read data stands one cycle only, zero after
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge clk);
    #1 chk(reg_rdata, 32'h0);
  endtask
  // write then read back with no gap between the strobes
  task automatic wrrd(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    m_reg[a-8'h13] = d[23:0];
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, {8'h0, m_reg[a-8'h13]});
  endtask
  task automatic cal(input int i, input logic [23:0] d);
    @(posedge clk);
    cal_we[i] <= 1'b1;
    cal_data <= d;
    @(posedge clk);
    cal_we <= 4'h0;
    m_reg[i] = d;
  endtask
  task automatic smp(input logic [23:0] v, input logic [2:0] d, input logic u);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_in <= '{dest: d, value: v};
    ubc <= u;
    @(posedge clk);
    sample_valid <= 1'b0;
    #1 chk({31'h0, result_valid}, 32'h1);
    chk({5'h0, result_out}, {5'h0, d, model(v, d, u)});
  endtask
  initial begin
    logic [7:0] a;
    rst_n = 1'b0;
    {reg_wr, reg_rd, sample_valid, ubc} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    cal_we = '0;
    cal_data = '0;
    sample_in = '0;
    m_reg = '{24'h0, 24'h0, 24'h800000, 24'h800000};
    m_choice = 16'h0;
    void'($urandom(74566));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, then an unmapped place
    for (int i = 0; i < 4; i++) rd(8'h13 + i[7:0], {8'h0, m_reg[i]});
    rd(8'h12, 32'h0);
    rd(8'h20, 32'h0);
    // every set code, each on two destinations, extreme offsets and gains
    wr(8'h12, 32'hFFFFE4E4);
    wr(8'h13, 32'h00800000);
    wr(8'h15, 32'h00FFFFFF);
    wr(8'h14, 32'h007FFFFF);
    wr(8'h16, 32'h00000001);
    for (int d = 0; d < 8; d++) begin
      smp(24'h7FFFFF, d[2:0], 1'b0);
      smp(24'h800000, d[2:0], 1'b1);
      smp(24'h000001, d[2:0], d[0]);
    end
    // clip high, zero gain, all-ones offset read as minus one
    wr(8'h13, 32'h00000000);
    wr(8'h15, 32'h00FFFFFF);
    smp(24'h7FFFFF, 3'h0, 1'b0);
    wr(8'h15, 32'h00000000);
    smp(24'h123456, 3'h0, 1'b1);
    wr(8'h14, 32'h00FFFFFF);
    wr(8'h16, 32'h00800000);
    smp(24'h000000, 3'h1, 1'b0);
    // random register contents, with readback and calibration overwrite
    for (int r = 0; r < 6; r++) begin
      for (int i = 0; i < 4; i++) wr(8'h13 + i[7:0], $urandom);
      wr(8'h12, $urandom);
      wrrd(8'h13, $urandom);
      for (int i = 0; i < 4; i++) rd(8'h13 + i[7:0], {8'h0, m_reg[i]});
      rd(8'h12, {16'h0, m_choice});
      if (r[0]) cal(r % 4, 24'($urandom));
      a = 8'h13 + 8'(r % 4);
      rd(a, {8'h0, m_reg[r%4]});
      for (int k = 0; k < 40; k++) smp(24'($urandom), 3'($urandom), 1'($urandom));
    end
    end_of_test();
  end
endmodule
`default_nettype wire
